// ==== verilog/memory_block_pkg.sv ====
package memory_block_pkg;
	// Memory geometry
	localparam int ADDR_W     = 7;
	localparam int DATA_W     = 16;
	localparam int DEPTH      = 128;
	// Product-term array geometry
	localparam int CELLS      = 16;
	localparam int OWN_TERMS  = 2;
	localparam int MAX_TERMS  = 32;
	localparam int MAX_SETS   = 15;
	localparam int SET_W      = 4;
	localparam int CLK_LINES  = 4;
	// Reset values
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;

	// Per-macrocell clear choice
	typedef enum logic [1:0] {
		CLR_NONE,
		CLR_FIRST,
		CLR_SECOND
	} clear_sel_e;

	// Write-side request from fabric
	typedef struct packed {
		logic              strobe;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} write_req_s;

	// Read-side request from fabric
	typedef struct packed {
		logic              strobe;
		logic [ADDR_W-1:0] addr;
	} read_req_s;

	// Per-side control: clock line select, enable, local clear
	typedef struct packed {
		logic [1:0] clk_sel;
		logic       clk_en;
		logic       local_clear;
	} side_ctrl_s;
endpackage : memory_block_pkg

// ==== verilog/product_term_array.sv ====
module product_term_array
	import memory_block_pkg::*;
(
	input  wire logic                          core_clk,
	input  wire logic                          reset,
	input  wire logic [CELLS*OWN_TERMS-1:0]    pterms,
	input  wire logic [CELLS*SET_W-1:0]        expander_sets,
	input  wire logic [CELLS*2-1:0]            clear_select,
	input  wire logic                          global_clear,
	input  wire logic                          local_clear,
	input  wire logic                          invert_first,
	input  wire logic                          invert_second,
	output logic      [CELLS-1:0]              cell_out
);
	logic             clear_first;
	logic             clear_second;
	logic [CELLS-1:0] sum;
	logic [CELLS-1:0] next_cell_out;

	// Two block clears, each with optional inversion
	assign clear_first  = global_clear ^ invert_first;
	assign clear_second = local_clear ^ invert_second;

	// OR plane: own two terms plus up to 15 borrowed pairs from the next cells, wrapping from cell 15 to cell 0;
	// a 4-bit set count cannot exceed 15, so no cell ever sees more than 32 terms
	always_comb begin
		int          n;
		int          src;
		logic [3:0]  sets;
		n    = 0;
		src  = 0;
		sets = 4'h0;
		for (int i = 0; i < CELLS; i++) begin
			sets   = expander_sets[i*SET_W +: SET_W];
			sum[i] = |pterms[i*OWN_TERMS +: OWN_TERMS];
			for (n = 1; n <= MAX_SETS; n++) begin
				src = (i + n) % CELLS;
				if (n <= int'(sets))
					sum[i] = sum[i] | (|pterms[src*OWN_TERMS +: OWN_TERMS]);
			end
		end
	end

	// Each cell picks the first clear, the second, or none
	always_comb begin
		for (int i = 0; i < CELLS; i++) begin
			case (clear_sel_e'(clear_select[i*2 +: 2]))
				CLR_FIRST:  next_cell_out[i] = clear_first ? 1'b0 : sum[i];
				CLR_SECOND: next_cell_out[i] = clear_second ? 1'b0 : sum[i];
				default:    next_cell_out[i] = sum[i];
			endcase
		end
	end

	// Chip reset clears every cell regardless of its choice
	always_ff @(posedge core_clk) begin
		if (reset)
			cell_out <= '0;
		else
			cell_out <= next_cell_out;
	end
endmodule : product_term_array

// ==== verilog/embedded_memory_block.sv ====
// How it works
// - two clears, from global and local lines
// - each cell selects first, second, or none
// - either block clear may be inverted
// - OR plane takes at most 32 terms
// - at most 15 borrowed pairs per cell
// - writes registered; optional read output pipeline stage
// - write and read in same period
// - write registers run on write clock
// - read registers run on read clock
// - separate enable and clear per side
// - side registers clear from local, global, chip reset; line history from chip reset only
// - side clocks picked from four dedicated lines
module embedded_memory_block
	import memory_block_pkg::*;
(
	input  wire logic                       core_clk,
	input  wire logic                       reset,
	input  wire logic [CLK_LINES-1:0]       clock_lines,
	input  wire logic                       global_clear,
	input  wire side_ctrl_s                 write_ctrl,
	input  wire side_ctrl_s                 read_ctrl,
	input  wire write_req_s                 write_req,
	input  wire read_req_s                  read_req,
	input  wire logic                       output_reg_en,
	output logic      [DATA_W-1:0]          read_data,
	input  wire logic [CELLS*OWN_TERMS-1:0] pterms,
	input  wire logic [CELLS*SET_W-1:0]     expander_sets,
	input  wire logic [CELLS*2-1:0]         clear_select,
	input  wire logic                       pterm_local_clear,
	input  wire logic                       invert_first,
	input  wire logic                       invert_second,
	output logic      [CELLS-1:0]           cell_out
);
	// Storage array; one word per address, never cleared
	logic [DATA_W-1:0]    mem [DEPTH];
	// Clock line history and per-side events
	logic [CLK_LINES-1:0] lines_q;
	logic [CLK_LINES-1:0] next_lines_q;
	logic                 write_tick;
	logic                 read_tick;
	logic                 write_take;
	logic                 read_take;
	logic                 write_clear;
	logic                 read_clear;
	// Write-side input registers and array write port
	write_req_s           wr_reg;
	write_req_s           next_wr_reg;
	logic                 mem_we;
	logic [ADDR_W-1:0]    mem_waddr;
	logic [DATA_W-1:0]    mem_wdata;
	// Read-side registers
	read_req_s            rd_reg;
	read_req_s            next_rd_reg;
	logic                 rd_pending;
	logic                 next_rd_pending;
	logic [DATA_W-1:0]    array_word;
	logic [DATA_W-1:0]    raw_data;
	logic [DATA_W-1:0]    next_raw_data;
	logic [DATA_W-1:0]    next_read_data;

	// Rising edge of the chosen dedicated clock line; the line must fall
	// between two ticks, or the second rise is never seen
	function automatic logic line_rise(input logic [CLK_LINES-1:0] now,
		input logic [CLK_LINES-1:0] prev, input logic [1:0] sel);
		line_rise = now[sel] & ~prev[sel];
	endfunction : line_rise

	// A side acts only where its tick, its enable and its strobe meet
	function automatic logic side_take(input logic tick, input side_ctrl_s ctrl,
		input logic strobe);
		side_take = tick & ctrl.clk_en & strobe;
	endfunction : side_take

	// Line history; it restarts low, so a line already high at reset release
	// still gives one tick on the first edge after it
	always_comb begin
		next_lines_q = clock_lines;
	end

	// History register, cleared by the chip reset only
	always_ff @(posedge core_clk) begin
		if (reset) begin
			lines_q <= '0;
		end else begin
			lines_q <= next_lines_q;
		end
	end

	// Side events; each side takes a request only on a rise of its own selected line,
	// so the two sides may run from lines of unrelated rates
	assign write_tick  = line_rise(clock_lines, lines_q, write_ctrl.clk_sel);
	assign read_tick   = line_rise(clock_lines, lines_q, read_ctrl.clk_sel);
	assign write_take  = side_take(write_tick, write_ctrl, write_req.strobe);
	assign read_take   = side_take(read_tick, read_ctrl, read_req.strobe);
	// Per-side clears; the sides never clear each other, but the global
	// clear reaches both at once
	assign write_clear = write_ctrl.local_clear | global_clear;
	assign read_clear  = read_ctrl.local_clear | global_clear;

	// Write input registers: capture on a taken write tick; address and data
	// are held here, so the fabric may change them right after the tick
	always_comb begin
		next_wr_reg        = wr_reg;
		next_wr_reg.strobe = 1'b0;   // Captured write commits once
		if (write_clear) begin
			next_wr_reg = '{strobe: 1'b0, addr: ADDR_RST, data: DATA_RST};
		end else if (write_take) begin
			next_wr_reg = write_req;
		end
	end

	// Write input register file
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_reg <= '{strobe: 1'b0, addr: ADDR_RST, data: DATA_RST};
		end else begin
			wr_reg <= next_wr_reg;
		end
	end

	// Array write port; a clear arriving after capture still kills the write,
	// so a side held in clear never changes the array
	always_comb begin
		mem_we    = wr_reg.strobe & ~write_clear;
		mem_waddr = wr_reg.addr;
		mem_wdata = wr_reg.data;
	end

	// Array write runs alongside any read; clears reach registers only
	always_ff @(posedge core_clk) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end
	end

	// Word at the registered read address; a write to the same address in an
	// overlapping period of the other clock leaves it undefined
	assign array_word = mem[rd_reg.addr];

	// Read address register; rd_pending marks the one edge on which the
	// array word belongs to a taken read
	always_comb begin
		next_rd_reg     = rd_reg;
		next_rd_pending = 1'b0;
		if (read_clear) begin
			next_rd_reg = '{strobe: 1'b0, addr: ADDR_RST};
		end else if (read_take) begin
			next_rd_reg     = read_req;
			next_rd_pending = 1'b1;
		end
	end

	// Read address register file
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rd_reg     <= '{strobe: 1'b0, addr: ADDR_RST};
			rd_pending <= 1'b0;
		end else begin
			rd_reg     <= next_rd_reg;
			rd_pending <= next_rd_pending;
		end
	end

	// Array read register, loaded one edge after the address is taken;
	// it feeds the optional output stage
	always_comb begin
		next_raw_data = raw_data;
		if (read_clear) begin
			next_raw_data = DATA_RST;
		end else if (rd_pending) begin
			next_raw_data = array_word;
		end
	end

	// Array read register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			raw_data <= DATA_RST;
		end else begin
			raw_data <= next_raw_data;
		end
	end

	// Output register: bypassed, or one extra read of latency. The pipelined
	// word only moves on the next taken read, which trades latency for timing
	always_comb begin
		next_read_data = read_data;
		if (read_clear) begin
			next_read_data = DATA_RST;
		end else if (!output_reg_en && rd_pending) begin
			next_read_data = array_word;
		end else if (output_reg_en && read_take) begin
			next_read_data = raw_data;
		end
	end

	// Output data register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			read_data <= DATA_RST;
		end else begin
			read_data <= next_read_data;
		end
	end

	// Product-term mode macrocells; they share the chip reset and the global
	// clear with the memory side but keep a local clear of their own
	product_term_array u_pterm (
		.core_clk      (core_clk),
		.reset         (reset),
		.pterms        (pterms),
		.expander_sets (expander_sets),
		.clear_select  (clear_select),
		.global_clear  (global_clear),
		.local_clear   (pterm_local_clear),
		.invert_first  (invert_first),
		.invert_second (invert_second),
		.cell_out      (cell_out)
	);
endmodule : embedded_memory_block

// ==== dv/fabric_model.sv ====
module fabric_model
	import memory_block_pkg::*;
(
	input  wire logic       core_clk,
	output logic [3:0]      clock_lines,
	output write_req_s      write_req,
	output read_req_s       read_req
);
	timeunit 1ns;
	timeprecision 1ns;
	// Lines idle low between ticks
	initial {clock_lines, write_req, read_req} = '0;
	// One tick: write on line 0, read on line 3, request held over the taking edge
	task automatic tick(input logic wr, s, input logic [6:0] a, input logic [15:0] d);
		@(posedge core_clk) #1;
		clock_lines = wr ? 4'h1 : 4'h8;
		if (wr) write_req = '{s, a, d};
		else read_req = '{s, a};
		@(posedge core_clk) #1;
		// Released buses show inverted junk so a stale value can never match
		clock_lines = '0;
		write_req = '{1'b0, ~write_req.addr, ~write_req.data};
		read_req = '{1'b0, ~read_req.addr};
	endtask : tick
endmodule : fabric_model

// ==== dv/memory_block_checker_sva.sv ====
module memory_block_checker
	import memory_block_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic [3:0]  clock_lines,
	input wire logic        global_clear,
	input wire side_ctrl_s  read_ctrl,
	input wire read_req_s   read_req,
	input wire logic        output_reg_en,
	input wire logic [15:0] read_data,
	input wire logic [31:0] pterms,
	input wire logic [63:0] expander_sets,
	input wire logic [31:0] clear_select,
	input wire logic        pterm_local_clear,
	input wire logic        invert_first,
	input wire logic        invert_second,
	input wire logic [15:0] cell_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (reset);
	logic [3:0] prev;
	logic       rq;
	// Read is taken on a selected line rise; history restarts at reset
	always_ff @(posedge core_clk) prev <= reset ? 4'h0 : clock_lines;
	assign rq = clock_lines[read_ctrl.clk_sel] & ~prev[read_ctrl.clk_sel] & read_ctrl.clk_en
		& read_req.strobe & ~read_ctrl.local_clear & ~global_clear;
	// Cell 0 stands for every cell, to keep the checker small
	property p_rst; $fell(reset) |-> read_data == '0 && cell_out == '0; endproperty
	a_rst: assert property (p_rst) else $error("not clear after reset");
	property p_gclr; global_clear |=> read_data == '0; endproperty
	a_gclr: assert property (p_gclr) else $error("global clear missed");
	property p_rclr; read_ctrl.local_clear |=> read_data == '0; endproperty
	a_rclr: assert property (p_rclr) else $error("read clear missed");
	property p_hold; $changed(read_data) && !output_reg_en && !$past(output_reg_en)
		|-> $past(rq, 2) || $past(global_clear || read_ctrl.local_clear || reset); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_first; clear_select[1:0] == 2'h1 && (global_clear ^ invert_first)
		|=> !cell_out[0]; endproperty
	a_first: assert property (p_first) else $error("first clear");
	property p_second; clear_select[1:0] == 2'h2 && (pterm_local_clear ^ invert_second)
		|=> !cell_out[0]; endproperty
	a_second: assert property (p_second) else $error("second clear");
	property p_own; clear_select[1:0] == 2'h0 && |pterms[1:0] |=> cell_out[0]; endproperty
	a_own: assert property (p_own) else $error("own term");
	property p_far; clear_select[1:0] == 2'h0 && expander_sets[3:0] == 4'hf && pterms[30]
		|=> cell_out[0]; endproperty
	a_far: assert property (p_far) else $error("far expander");
	property p_none; clear_select[1:0] == 2'h0 && expander_sets[3:0] == 4'h0
		&& pterms[1:0] == 2'h0 |=> !cell_out[0]; endproperty
	a_none: assert property (p_none) else $error("no terms");
endmodule : memory_block_checker
bind embedded_memory_block memory_block_checker memory_block_checker_i (
	.core_clk          (core_clk),
	.reset             (reset),
	.clock_lines       (clock_lines),
	.global_clear      (global_clear),
	.read_ctrl         (read_ctrl),
	.read_req          (read_req),
	.output_reg_en     (output_reg_en),
	.read_data         (read_data),
	.pterms            (pterms),
	.expander_sets     (expander_sets),
	.clear_select      (clear_select),
	.pterm_local_clear (pterm_local_clear),
	.invert_first      (invert_first),
	.invert_second     (invert_second),
	.cell_out          (cell_out)
);

// ==== dv/tb_embedded_memory_block.sv ====
module tb_embedded_memory_block import memory_block_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, reset = 1, global_clear = 0, output_reg_en = 0;
	logic pterm_local_clear = 0, invert_first = 0, invert_second = 0;
	logic [31:0] pterms = '0, clear_select = '0;
	logic [63:0] expander_sets = '0;
	side_ctrl_s write_ctrl = '{2'h0, 1'b1, 1'b0}, read_ctrl = '{2'h3, 1'b1, 1'b0};
	logic [3:0] clock_lines;
	write_req_s write_req;
	read_req_s read_req;
	logic [15:0] read_data, cell_out;
	int n_mismatch = 0, compares = 0;
	always #25 core_clk = ~core_clk;
	fabric_model fabric_model_i (.core_clk(core_clk), .clock_lines(clock_lines),
		.write_req(write_req), .read_req(read_req));
	embedded_memory_block embedded_memory_block_i (
		.core_clk          (core_clk),
		.reset             (reset),
		.clock_lines       (clock_lines),
		.global_clear      (global_clear),
		.write_ctrl        (write_ctrl),
		.read_ctrl         (read_ctrl),
		.write_req         (write_req),
		.read_req          (read_req),
		.output_reg_en     (output_reg_en),
		.read_data         (read_data),
		.pterms            (pterms),
		.expander_sets     (expander_sets),
		.clear_select      (clear_select),
		.pterm_local_clear (pterm_local_clear),
		.invert_first      (invert_first),
		.invert_second     (invert_second),
		.cell_out          (cell_out)
	);
	task automatic check(input string what, input logic [15:0] exp, got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Read data lands one edge after the taking edge and is checked one edge later
	task automatic rd(input logic [6:0] a, input logic [15:0] exp);
		fabric_model_i.tick(1'b0, 1'b1, a, 16'h0);
		repeat (2) @(posedge core_clk);
		#1 check("read_data", exp, read_data);
	endtask : rd
	// Cell 0 with flags {global, local, invert first, invert second};
	// every other cell borrows nothing and uses no clear, so cell 15 shows its own pair
	task automatic pt(input logic [31:0] p, input logic [3:0] n, input logic [1:0] s,
		input logic [3:0] c, input logic e);
		{pterms, expander_sets[3:0], clear_select[1:0]} = {p, n, s};
		{global_clear, pterm_local_clear, invert_first, invert_second} = c;
		repeat (2) @(posedge core_clk);
		#1 check("cell_out", {|p[31:30], 14'h0, e}, cell_out);
	endtask : pt
	task automatic t_mem;
		fabric_model_i.tick(1'b1, 1'b1, 7'h05, 16'h1234);
		fabric_model_i.tick(1'b1, 1'b1, 7'h7f, 16'hbeef);
		fabric_model_i.tick(1'b1, 1'b0, 7'h05, 16'hffff);
		write_ctrl.clk_en = 1'b0;
		fabric_model_i.tick(1'b1, 1'b1, 7'h7f, 16'h0000);
		write_ctrl = '{2'h0, 1'b1, 1'b1};
		fabric_model_i.tick(1'b1, 1'b1, 7'h05, 16'haaaa);
		write_ctrl.local_clear = 1'b0;
		rd(7'h05, 16'h1234);
		rd(7'h7f, 16'hbeef);
	endtask : t_mem
	task automatic t_clear;
		read_ctrl.local_clear = 1'b1;
		@(posedge core_clk) #1 read_ctrl.local_clear = 1'b0;
		check("read_data", 16'h0, read_data);
		output_reg_en = 1'b1;
		fabric_model_i.tick(1'b0, 1'b1, 7'h05, 16'h0);
		rd(7'h7f, 16'h1234);
		global_clear = 1'b1;
		@(posedge core_clk) #1 global_clear = 1'b0;
		check("read_data", 16'h0, read_data);
	endtask : t_clear
	task automatic t_pt;
		pt(32'h1, 4'h0, 2'h0, 4'h0, 1'b1);
		pt(32'h0, 4'h0, 2'h0, 4'h0, 1'b0);
		pt(32'h4000_0000, 4'hf, 2'h0, 4'h0, 1'b1);
		pt(32'h4000_0000, 4'he, 2'h0, 4'h0, 1'b0);
		pt(32'h1, 4'h0, 2'h1, 4'h8, 1'b0);
		pt(32'h1, 4'h0, 2'h1, 4'h2, 1'b0);
		pt(32'h1, 4'h0, 2'h1, 4'h4, 1'b1);
		pt(32'h1, 4'h0, 2'h2, 4'h4, 1'b0);
		pt(32'h1, 4'h0, 2'h2, 4'h1, 1'b0);
		pt(32'h1, 4'h0, 2'h3, 4'hc, 1'b1);
	endtask : t_pt
	task automatic end_sim;
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	// Main sequence after three reset cycles
	initial begin
		repeat (3) @(posedge core_clk);
		#1 reset = 1'b0;
		t_mem();
		t_clear();
		t_pt();
		end_sim();
	end
	// Whole run needs well under 30 us
	initial begin
		#100us;
		n_mismatch++;
		end_sim();
	end
endmodule : tb_embedded_memory_block
